// file: bench/freq_cfg_properties.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module freq_cfg_properties
  import freq_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic avg_deadband_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [3:0] freq_source_sel,
  input wire logic [1:0] run_source_sel,
  input wire logic [8:0] base_hz_m1,
  input wire logic [8:0] max_hz_m1,
  input wire logic [8:0] base_hz_m2,
  input wire logic [8:0] max_hz_m2,
  input wire logic [2:0] analog_input_sel,
  input wire logic [11:0] range_start_dhz,
  input wire logic [4:0] avg_sample_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_ack; (reg_wr || reg_rd) |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_idle; !(reg_wr || reg_rd) |=> !reg_ack && !reg_err; endproperty
  a_idle: assert property (p_idle) else $error("ack or err without request");
  property p_fsrc; reg_wr && reg_addr == ADDR_FREQ_SRC && reg_wdata == 16'h000a |=> freq_source_sel == 4'ha;
  endproperty
  a_fsrc: assert property (p_fsrc) else $error("calculated source not taken");
  property p_run; run_source_sel != 2'h0; endproperty
  a_run: assert property (p_run) else $error("run source code zero");
  property p_m1; base_hz_m1 >= 9'h01e && base_hz_m1 <= max_hz_m1 && max_hz_m1 <= 9'h190; endproperty
  a_m1: assert property (p_m1) else $error("motor 1 limits broken");
  property p_m2; base_hz_m2 >= 9'h01e && base_hz_m2 <= max_hz_m2 && max_hz_m2 <= 9'h190; endproperty
  a_m2: assert property (p_m2) else $error("motor 2 limits broken");
  property p_ain; analog_input_sel inside {3'h0, [3'h2:3'h5]}; endproperty
  a_ain: assert property (p_ain) else $error("analog select code illegal");
  property p_rng; range_start_dhz <= 12'hfa0; endproperty
  a_rng: assert property (p_rng) else $error("start frequency above limit");
  property p_avg; avg_deadband_en |-> avg_sample_count == 5'h10; endproperty
  a_avg: assert property (p_avg) else $error("deadband without 16 samples");
  property p_avg_wr; reg_wr && reg_addr == ADDR_AVG && reg_wdata == 16'h0011 |=> avg_deadband_en; endproperty
  a_avg_wr: assert property (p_avg_wr) else $error("setting 17 gave no deadband");
  property p_keep; reg_wr && reg_addr == ADDR_AIN_SEL && reg_wdata == 16'h0001 |=> reg_err && $stable(analog_input_sel);
  endproperty
  a_keep: assert property (p_keep) else $error("bad code stored");
endmodule : freq_cfg_properties
bind freq_source_config_regs freq_cfg_properties u_props (.*);

// file: bench/net_master_model.sv
`timescale 1ns/1ps
// ----
// Network master
// ----
module net_master_model (
  input wire logic clk,
  input wire logic reg_ack,
  input wire logic reg_err,
  input wire logic [15:0] reg_rdata,
  output logic reg_wr = 1'b0,
  output logic reg_rd = 1'b0,
  output logic [15:0] reg_addr = 16'h0000,
  output logic [15:0] reg_wdata = 16'h0000
);
  logic ack_seen, err_seen;
  logic [15:0] rdata_seen;
  // Released lines show the inverse, so stale values never pass for live ones
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    // Answer stands for one cycle after the taking edge, so read it mid-cycle
    @(negedge clk);
    ack_seen = reg_ack;
    err_seen = reg_err;
    rdata_seen = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : xfer
endmodule : net_master_model

// file: bench/test_inverter_freq_source_config_regs.sv
`timescale 1ns/1ps
// ----
// Register bank tests
// ----
module test_inverter_freq_source_config_regs;
  import freq_cfg_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reg_wr, reg_rd, reg_ack, reg_err, below_start_zero, avg_deadband_en;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] freq_source_sel;
  logic [1:0] run_source_sel;
  logic [8:0] base_hz_m1, max_hz_m1, base_hz_m2, max_hz_m2;
  logic [2:0] analog_input_sel;
  logic [11:0] range_start_dhz, range_end_dhz;
  logic [6:0] range_start_pct, range_end_pct;
  logic [4:0] avg_sample_count;
  int errors = 0;
  int samples_checked = 0;
  // Rows: write, address, data, expected err, expected read data
  int ops [40][5] = '{
    '{0,ADDR_FREQ_SRC,0,0,0},'{0,ADDR_RUN_SRC,0,0,1},'{0,ADDR_BASE_M1,0,0,50},'{0,ADDR_MAX_M2,0,0,50},
    '{0,ADDR_AVG,0,0,8},'{0,ADDR_RNG_END_O,0,0,100},
    '{1,ADDR_FREQ_SRC,10,0,0},'{1,ADDR_FREQ_SRC,4,1,0},'{0,ADDR_FREQ_SRC,0,0,10},
    '{1,ADDR_RUN_SRC,0,1,0},'{1,ADDR_RUN_SRC,3,0,0},'{0,ADDR_RUN_SRC,0,0,3},
    '{1,ADDR_MAX_M1,401,1,0},'{1,ADDR_MAX_M1,400,0,0},'{1,ADDR_BASE_M1,29,1,0},
    '{1,ADDR_BASE_M1,400,0,0},'{1,ADDR_MAX_M1,399,1,0},'{0,ADDR_MAX_M1,0,0,400},
    '{1,ADDR_BASE_M2,51,1,0},'{1,ADDR_MAX_M2,400,0,0},'{1,ADDR_BASE_M2,51,0,0},'{1,ADDR_MAX_M2,50,1,0},
    '{1,ADDR_AIN_SEL,1,1,0},'{1,ADDR_AIN_SEL,5,0,0},'{1,ADDR_AIN_SEL,6,1,0},'{0,ADDR_AIN_SEL,0,0,5},
    '{1,ADDR_RNG_START_F,4001,1,0},'{1,ADDR_RNG_START_F,4000,0,0},
    '{1,ADDR_RNG_END_F,4001,1,0},'{1,ADDR_RNG_END_F,4000,0,0},
    '{1,ADDR_RNG_START_O,101,1,0},'{1,ADDR_RNG_START_O,100,0,0},
    '{1,ADDR_RNG_END_O,0,0,0},'{0,ADDR_RNG_END_O,0,0,0},
    '{1,ADDR_START_BEH,2,1,0},'{1,ADDR_START_BEH,1,0,0},
    '{1,ADDR_AVG,0,1,0},'{1,ADDR_AVG,18,1,0},
    '{1,16'h1021,5,1,0},'{0,16'h1021,0,1,0}};
  always #4 clk = ~clk;
  freq_source_config_regs u_dut (.*);
  net_master_model u_net (.*);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic access(input int w, input int a, input int d, input int e_err, input int e_rd);
    u_net.xfer(w[0], a[15:0], d[15:0]);
    chk("ack", 16'h0001, {15'h0000, u_net.ack_seen});
    chk("err", e_err[15:0], {15'h0000, u_net.err_seen});
    if (w == 0) chk("rdata", e_rd[15:0], u_net.rdata_seen);
  endtask : access
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 40; i++) access(ops[i][0], ops[i][1], ops[i][2], ops[i][3], ops[i][4]);
    chk("fsrc", 16'h000a, {12'h000, freq_source_sel});
    chk("base2", 16'h0033, {7'h00, base_hz_m2});
    chk("ain", 16'h0005, {13'h0000, analog_input_sel});
    chk("end_f", 16'h0fa0, {4'h0, range_end_dhz});
    chk("start_pct", 16'h0064, {9'h000, range_start_pct});
    chk("zero", 16'h0001, {15'h0000, below_start_zero});
    chk("run", 16'h0003, {14'h0000, run_source_sel});
    chk("base1", 16'h0190, {7'h00, base_hz_m1});
    chk("max1", 16'h0190, {7'h00, max_hz_m1});
    chk("max2", 16'h0190, {7'h00, max_hz_m2});
    chk("start_f", 16'h0fa0, {4'h0, range_start_dhz});
    chk("end_pct", 16'h0000, {9'h000, range_end_pct});
    for (int n = 1; n <= 17; n++) begin
      access(1, ADDR_AVG, n, 0, 0);
      chk("avg", (n > 16) ? 16'h0010 : n[15:0], {11'h000, avg_sample_count});
      chk("dband", {15'h0000, n == 17}, {15'h0000, avg_deadband_en});
    end
    conclude();
  end
  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule : test_inverter_freq_source_config_regs

// file: inc/freq_cfg_pkg.sv
// Operation
// - Frequency source code: 0 pot, 1 terminal, 2 preset, 3 network, 10 calculated.
// - Run command source code: 1 terminal, 2 keypad run key, 3 network.
// - Motor 1 base frequency in hertz, 30 up to motor 1 maximum.
// - Motor 2 base frequency in hertz, 30 up to motor 2 maximum.
// - Motor 1 maximum frequency in hertz, base up to 400.
// - Motor 2 maximum frequency in hertz, base up to 400.
// - Analog select code 0, 2, 3, 4 or 5 picks the active input.
// - Range start frequency 0 to 4000 in 0.1 Hz steps.
// - Range end frequency 0 to 4000 in 0.1 Hz steps.
// - Range start offset 0 to 100 percent.
// - Range end offset 0 to 100 percent.
// - Below range start: code 0 gives start frequency, code 1 gives zero.
// - Average 1 to 16 samples; 17 averages 16 with deadband.
package freq_cfg_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [15:0] ADDR_FREQ_SRC = 16'h1019;
  localparam logic [15:0] ADDR_RUN_SRC = 16'h101a;
  localparam logic [15:0] ADDR_BASE_M1 = 16'h101b;
  localparam logic [15:0] ADDR_MAX_M1 = 16'h101c;
  localparam logic [15:0] ADDR_AIN_SEL = 16'h101d;
  localparam logic [15:0] ADDR_RNG_START_F = 16'h1020;
  localparam logic [15:0] ADDR_RNG_END_F = 16'h1022;
  localparam logic [15:0] ADDR_RNG_START_O = 16'h1023;
  localparam logic [15:0] ADDR_RNG_END_O = 16'h1024;
  localparam logic [15:0] ADDR_START_BEH = 16'h1025;
  localparam logic [15:0] ADDR_AVG = 16'h1026;
  localparam logic [15:0] ADDR_BASE_M2 = 16'h150c;
  localparam logic [15:0] ADDR_MAX_M2 = 16'h150d;
  // ----------------------------------------
  // Limits and codes
  // ----------------------------------------
  localparam logic [15:0] BASE_MIN_HZ = 16'h001e;
  localparam logic [15:0] MAX_LIMIT_HZ = 16'h0190;
  localparam logic [15:0] FREQ_LIMIT_DHZ = 16'h0fa0;
  localparam logic [15:0] PCT_LIMIT = 16'h0064;
  localparam logic [15:0] FSRC_CALC = 16'h000a;
  localparam logic [15:0] FSRC_LAST = 16'h0003;
  localparam logic [15:0] RSRC_FIRST = 16'h0001;
  localparam logic [15:0] RSRC_LAST = 16'h0003;
  localparam logic [15:0] AIN_SWITCH = 16'h0000;
  localparam logic [15:0] AIN_FIRST_PAIR = 16'h0002;
  localparam logic [15:0] AIN_LAST = 16'h0005;
  localparam logic [15:0] BEH_LAST = 16'h0001;
  localparam logic [15:0] AVG_MIN = 16'h0001;
  localparam logic [15:0] AVG_MAX = 16'h0011;
  localparam logic [15:0] AVG_DEADBAND = 16'h0011;
  localparam logic [4:0] AVG_FULL = 5'h10;
  // ----------------------------------------
  // Reset values (neutral, in range)
  // ----------------------------------------
  localparam logic [15:0] RST_FREQ_SRC = 16'h0000;
  localparam logic [15:0] RST_RUN_SRC = 16'h0001;
  localparam logic [15:0] RST_BASE = 16'h0032;
  localparam logic [15:0] RST_MAX = 16'h0032;
  localparam logic [15:0] RST_AIN_SEL = 16'h0000;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_END_PCT = 16'h0064;
  localparam logic [15:0] RST_AVG = 16'h0008;
endpackage : freq_cfg_pkg

// file: verilog/freq_source_config_regs.sv
`timescale 1ns/1ps
module freq_source_config_regs
  import freq_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  output logic reg_err,
  output logic [3:0] freq_source_sel,
  output logic [1:0] run_source_sel,
  output logic [8:0] base_hz_m1,
  output logic [8:0] max_hz_m1,
  output logic [8:0] base_hz_m2,
  output logic [8:0] max_hz_m2,
  output logic [2:0] analog_input_sel,
  output logic [11:0] range_start_dhz,
  output logic [11:0] range_end_dhz,
  output logic [6:0] range_start_pct,
  output logic [6:0] range_end_pct,
  output logic below_start_zero,
  output logic [4:0] avg_sample_count,
  output logic avg_deadband_en
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] freq_src_r;
  logic [15:0] run_src_r;
  logic [15:0] base_m1_r;
  logic [15:0] max_m1_r;
  logic [15:0] base_m2_r;
  logic [15:0] max_m2_r;
  logic [15:0] ain_sel_r;
  logic [15:0] rng_start_f_r;
  logic [15:0] rng_end_f_r;
  logic [15:0] rng_start_o_r;
  logic [15:0] rng_end_o_r;
  logic [15:0] start_beh_r;
  logic [15:0] avg_r;
  logic [15:0] rdata_nxt;
  logic hit;
  logic ok;
  logic [15:0] v;
  logic wr_take;

  assign v = reg_wdata;

  // ----------------------------------------
  // Write qualification
  // ----------------------------------------
  // A rejected value or an unmapped address leaves every register as it was
  assign wr_take = reg_wr && hit && ok;

  // ----------------------------------------
  // Decode and range check
  // ----------------------------------------
  always_comb begin
    hit = 1'b1;
    ok = 1'b0;
    rdata_nxt = 16'h0000;
    case (reg_addr)
      ADDR_FREQ_SRC: begin
        rdata_nxt = freq_src_r;
        ok = (v <= FSRC_LAST) || (v == FSRC_CALC);
      end
      ADDR_RUN_SRC: begin
        rdata_nxt = run_src_r;
        ok = (v >= RSRC_FIRST) && (v <= RSRC_LAST);
      end
      ADDR_BASE_M1: begin
        rdata_nxt = base_m1_r;
        ok = (v >= BASE_MIN_HZ) && (v <= max_m1_r);
      end
      ADDR_MAX_M1: begin
        rdata_nxt = max_m1_r;
        ok = (v >= base_m1_r) && (v <= MAX_LIMIT_HZ);
      end
      ADDR_BASE_M2: begin
        rdata_nxt = base_m2_r;
        ok = (v >= BASE_MIN_HZ) && (v <= max_m2_r);
      end
      ADDR_MAX_M2: begin
        rdata_nxt = max_m2_r;
        ok = (v >= base_m2_r) && (v <= MAX_LIMIT_HZ);
      end
      ADDR_AIN_SEL: begin
        rdata_nxt = ain_sel_r;
        ok = (v == AIN_SWITCH) || ((v >= AIN_FIRST_PAIR) && (v <= AIN_LAST));
      end
      ADDR_RNG_START_F: begin
        rdata_nxt = rng_start_f_r;
        ok = (v <= FREQ_LIMIT_DHZ);
      end
      ADDR_RNG_END_F: begin
        rdata_nxt = rng_end_f_r;
        ok = (v <= FREQ_LIMIT_DHZ);
      end
      ADDR_RNG_START_O: begin
        rdata_nxt = rng_start_o_r;
        ok = (v <= PCT_LIMIT);
      end
      ADDR_RNG_END_O: begin
        rdata_nxt = rng_end_o_r;
        ok = (v <= PCT_LIMIT);
      end
      ADDR_START_BEH: begin
        rdata_nxt = start_beh_r;
        ok = (v <= BEH_LAST);
      end
      ADDR_AVG: begin
        rdata_nxt = avg_r;
        ok = (v >= AVG_MIN) && (v <= AVG_MAX);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  // Each register only moves on a legal write to its own address
  always_ff @(posedge clk) begin
    if (!resetn) begin
      freq_src_r <= RST_FREQ_SRC;
    end else if (wr_take && (reg_addr == ADDR_FREQ_SRC)) begin
      freq_src_r <= v;
    end
  end

  // Code 0 is refused, so the run source is never left unset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      run_src_r <= RST_RUN_SRC;
    end else if (wr_take && (reg_addr == ADDR_RUN_SRC)) begin
      run_src_r <= v;
    end
  end

  // ----------------------------------------
  // Motor frequency limits
  // ----------------------------------------
  // Base and maximum check each other, so raise the maximum first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      base_m1_r <= RST_BASE;
    end else if (wr_take && (reg_addr == ADDR_BASE_M1)) begin
      base_m1_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      max_m1_r <= RST_MAX;
    end else if (wr_take && (reg_addr == ADDR_MAX_M1)) begin
      max_m1_r <= v;
    end
  end

  // The second motor keeps its own pair, checked the same way
  always_ff @(posedge clk) begin
    if (!resetn) begin
      base_m2_r <= RST_BASE;
    end else if (wr_take && (reg_addr == ADDR_BASE_M2)) begin
      base_m2_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      max_m2_r <= RST_MAX;
    end else if (wr_take && (reg_addr == ADDR_MAX_M2)) begin
      max_m2_r <= v;
    end
  end

  // ----------------------------------------
  // Analog input mapping
  // ----------------------------------------
  // Start and end points are not cross-checked; their order is the user's
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ain_sel_r <= RST_AIN_SEL;
    end else if (wr_take && (reg_addr == ADDR_AIN_SEL)) begin
      ain_sel_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rng_start_f_r <= RST_ZERO;
    end else if (wr_take && (reg_addr == ADDR_RNG_START_F)) begin
      rng_start_f_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rng_end_f_r <= RST_ZERO;
    end else if (wr_take && (reg_addr == ADDR_RNG_END_F)) begin
      rng_end_f_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rng_start_o_r <= RST_ZERO;
    end else if (wr_take && (reg_addr == ADDR_RNG_START_O)) begin
      rng_start_o_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rng_end_o_r <= RST_END_PCT;
    end else if (wr_take && (reg_addr == ADDR_RNG_END_O)) begin
      rng_end_o_r <= v;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      start_beh_r <= RST_ZERO;
    end else if (wr_take && (reg_addr == ADDR_START_BEH)) begin
      start_beh_r <= v;
    end
  end

  // ----------------------------------------
  // Input averaging
  // ----------------------------------------
  // Setting 0 and anything past 17 are refused
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avg_r <= RST_AVG;
    end else if (wr_take && (reg_addr == ADDR_AVG)) begin
      avg_r <= v;
    end
  end

  // Decoded at write time so both outputs leave straight from flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avg_deadband_en <= (RST_AVG == AVG_DEADBAND);
      avg_sample_count <= (RST_AVG == AVG_DEADBAND) ? AVG_FULL : RST_AVG[4:0];
    end else if (wr_take && (reg_addr == ADDR_AVG)) begin
      avg_deadband_en <= (v == AVG_DEADBAND);
      avg_sample_count <= (v == AVG_DEADBAND) ? AVG_FULL : v[4:0];
    end
  end

  // ----------------------------------------
  // Response
  // ----------------------------------------
  // One pulse per request, whatever the outcome
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_ack <= 1'b0;
    end else begin
      reg_ack <= reg_wr || reg_rd;
    end
  end

  // Error covers both unmapped address and a rejected write value
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_err <= 1'b0;
    end else begin
      reg_err <= (reg_wr || reg_rd) && (!hit || (reg_wr && !ok));
    end
  end

  // Read data holds between reads, so a slow master can fetch it late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  // Stored words are range checked, so the dropped upper bits are zero
  assign freq_source_sel = freq_src_r[3:0];
  assign run_source_sel = run_src_r[1:0];
  assign base_hz_m1 = base_m1_r[8:0];
  assign base_hz_m2 = base_m2_r[8:0];
  assign max_hz_m1 = max_m1_r[8:0];
  assign max_hz_m2 = max_m2_r[8:0];
  assign analog_input_sel = ain_sel_r[2:0];
  assign range_start_dhz = rng_start_f_r[11:0];
  assign range_end_dhz = rng_end_f_r[11:0];
  assign range_start_pct = rng_start_o_r[6:0];
  assign range_end_pct = rng_end_o_r[6:0];
  assign below_start_zero = start_beh_r[0];
endmodule : freq_source_config_regs
